// ===== rtl/hed_pkg.sv
package hed_pkg;
   // ****************************************************************
   // widths and entry offsets
   // ****************************************************************
   localparam int XLEN = 64;
   localparam logic [13:0] OFS_RESET   = 14'h0000;
   localparam logic [13:0] OFS_IACC    = 14'h0080;
   localparam logic [13:0] OFS_INTR    = 14'h0100;
   localparam logic [13:0] OFS_ITBM    = 14'h0180;
   localparam logic [13:0] OFS_DMISS   = 14'h0200;
   localparam logic [13:0] OFS_DMISS2  = 14'h0280;
   localparam logic [13:0] OFS_UNAL    = 14'h0300;
   localparam logic [13:0] OFS_DFLT    = 14'h0380;
   localparam logic [13:0] OFS_HWERR   = 14'h0400;
   localparam logic [13:0] OFS_ILLOP   = 14'h0480;
   localparam logic [13:0] OFS_ARITHMETIC_ENTRY   = 14'h0500;
   localparam logic [13:0] OFS_FPDIS   = 14'h0580;
   localparam logic [63:0] BASE_RESET  = 64'h0000000000000000;
   localparam logic [63:0] RET_RESET   = 64'h0000000000000001;
   localparam logic [1:0]  MODE_KERNEL = 2'h0;
   localparam logic [7:0]  FN_ILL_LO   = 8'h40;
   localparam logic [7:0]  FN_ILL_HI   = 8'h7f;
   localparam logic [7:0]  FN_UNPRIV_MAX = 8'hbf;
   localparam logic [7:0]  FN_PRIV_MAX = 8'h3f;
   localparam int          FLOW_MIN    = 2;
   localparam logic [1:0]  FLOW_CNT    = 2'(FLOW_MIN);
   localparam int          NSCRATCH    = 24;
   localparam int          NSHADOW     = 8;
   localparam logic [4:0]  REG_R8      = 5'h08;
   localparam logic [4:0]  REG_R14     = 5'h0e;
   localparam logic [4:0]  REG_R25     = 5'h19;

   // ****************************************************************
   // event inputs
   // ****************************************************************
   typedef struct packed {
      logic reset_req;
      logic iacc;
      logic intr;
      logic itb_miss;
      logic icache_miss;
      logic dmiss;
      logic dmiss2;
      logic sign_err;
      logic unal;
      logic data_fault_entry;
      logic hwerr;
      logic illop;
      logic arithmetic_entry;
      logic fp_op;
      logic fp_bad_type;
      logic replay;
      logic precise;
   } hed_evt_t;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_DRAIN = 2'b01,
      ST_ISSUE = 2'b11,
      ST_FLOW  = 2'b10
   } hed_state_t;
endpackage

// ===== rtl/hed_prio.sv
`timescale 1ns/1ps
module hed_prio
   import hed_pkg::*;
(
   input  hed_evt_t    ev,
   input  logic        float_enable_bit,
   output logic        hit,
   output logic [13:0] ofs
);
   logic dmiss_eff;
   logic fp_dis;
   // ****************************************************************
   // priority selection of trap entry
   // ****************************************************************
   always_comb begin
      dmiss_eff = ev.dmiss & ~ev.sign_err;
      fp_dis    = ev.fp_op & (~float_enable_bit | ev.fp_bad_type);
      hit = 1'b1;
      ofs = OFS_RESET;
      if (ev.reset_req) begin
         ofs = OFS_RESET;
      end else if (ev.iacc) begin
         ofs = OFS_IACC;
      end else if (ev.icache_miss & ev.itb_miss) begin
         ofs = OFS_ITBM;
      end else if (ev.intr) begin
         ofs = OFS_INTR;
      end else if (ev.itb_miss) begin
         ofs = OFS_ITBM;
      end else if (dmiss_eff) begin
         ofs = OFS_DMISS;
      end else if (ev.dmiss2 & ~ev.sign_err) begin
         ofs = OFS_DMISS2;
      end else if (ev.unal) begin
         ofs = OFS_UNAL;
      end else if (ev.data_fault_entry | (ev.sign_err & (ev.dmiss | ev.dmiss2))) begin
         ofs = OFS_DFLT;
      end else if (ev.hwerr) begin
         ofs = OFS_HWERR;
      end else if (ev.illop) begin
         ofs = OFS_ILLOP;
      end else if (ev.arithmetic_entry) begin
         ofs = OFS_ARITHMETIC_ENTRY;
      end else if (fp_dis) begin
         ofs = OFS_FPDIS;
      end else begin
         hit = 1'b0;
      end
   end
endmodule

// ===== rtl/hed_scratch.sv
`timescale 1ns/1ps
module hed_scratch
   import hed_pkg::*;
#(
   parameter int DEPTH = NSCRATCH
)(
   input  logic          clk,
   input  logic          we,
   input  logic [4:0]    waddr,
   input  logic [XLEN-1:0] wdata,
   input  logic [4:0]    raddr,
   output logic [XLEN-1:0] rdata
);
   logic [XLEN-1:0] mem [DEPTH];
   // ****************************************************************
   // scratch bank, written and read by internal register moves
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (we && (int'(waddr) < DEPTH)) begin
         mem[waddr] <= wdata;
      end
   end

   // read is combinational so the owner's output flop gives one cycle latency
   always_comb begin
      rdata = (int'(raddr) < DEPTH) ? mem[raddr] : '0;
   end
endmodule

// ===== rtl/hed_dispatch.sv
`timescale 1ns/1ps
// Behaviour
// - entering a handler sets PC bit 0 and keeps it as mode flag
// - fetch address ignores PC bit 0 in handler mode
// - return jumps to saved address, mode from its bit 0
// - drain pipeline, save current PC, then dispatch
// - return with bit 0 clear re-enables interrupts and mapping
// - reset enters handler mode at offset zero
// - shadow registers replace R8-R14 and R25 in mode with enable
// - 24 scratch registers reached only by internal register moves
// - call entries at 2000 privileged and above for unprivileged
// - call issues to pipe E1 with minimal barrier stall
// - call saves next PC and pushes it on return stack
// - illegal call function codes start the illegal opcode trap
// - call target built from base and function field bits
// - a call takes at least four cycles total
// - trap loads return address and performs barrier
// - return stack gets trapping PC if precise, later PC otherwise
// - replay is handled without handler entry
// - high priority trap entries and their offsets
// - lower priority entries hardware error, illegal, arithmetic
// - float disabled trap on disabled float op or bad type
// - data miss suppressed by sign check error
// - instruction cache miss swaps translation miss and interrupt
// - interrupts held off in handler mode
// - instruction mapping off in handler mode, data mapping on
module hed_dispatch
   import hed_pkg::*;
(
   input  logic            CLK_SYS,
   input  logic            RST,
   input  hed_evt_t        EVT,
   input  logic [XLEN-1:0] CUR_PC,
   input  logic [XLEN-1:0] LATER_PC,
   input  logic            PIPE_EMPTY,
   input  logic            CALL_VALID,
   input  logic [XLEN-1:0] CALL_NEXT_PC,
   input  logic [7:0]      CALL_FUNC,
   input  logic            RET_VALID,
   input  logic            IPR_WE,
   input  logic            IPR_RE,
   input  logic [4:0]      IPR_ADDR,
   input  logic [XLEN-1:0] IPR_WDATA,
   input  logic            BASE_WE,
   input  logic            CTL_WE,
   input  logic [1:0]      CTL_MODE,
   input  logic            CTL_SHADOW,
   input  logic            CTL_FLOAT,
   input  logic [4:0]      GPR_ADDR,
   output logic            REDIRECT,
   output logic [XLEN-1:0] NEW_PC,
   output logic [XLEN-1:0] FETCH_PC,
   output logic            HANDLER_MODE,
   output logic            INTR_ENABLE,
   output logic            IMAP_ENABLE,
   output logic            DMAP_ENABLE,
   output logic            DRAIN_REQ,
   output logic            ISSUE_STALL,
   output logic            ISSUE_E1,
   output logic            RPS_PUSH,
   output logic [XLEN-1:0] RPS_PC,
   output logic [XLEN-1:0] EXC_RET,
   output logic            USE_SHADOW,
   output logic [2:0]      SHADOW_IDX,
   output logic [XLEN-1:0] IPR_RDATA
);
   // ****************************************************************
   // state record
   // ****************************************************************
   typedef struct packed {
      hed_state_t      st;
      logic [1:0]      flow;
      logic            is_call;
      logic [XLEN-1:0] target;
      logic [XLEN-1:0] ret;
      logic [XLEN-1:0] base;
      logic [XLEN-1:0] pc;
      logic [XLEN-1:0] rps_pc;
      logic            mode;
      logic            intr_en;
      logic            imap_en;
      logic            dmap_en;
      logic [1:0]      cur_mode;
      logic            shadow_en;
      logic            float_en;
      logic            redirect;
      logic            drain;
      logic            stall;
      logic            e1;
      logic            rps_push;
      logic            use_shadow;
      logic [2:0]      shadow_idx;
   } hed_reg_t;

   hed_reg_t    r;
   hed_reg_t    next_r;
   logic        trap_hit;
   logic [13:0] trap_ofs;
   logic        call_illegal;
   logic        call_kernel;
   logic [XLEN-1:0] scratch_rdata;
   hed_evt_t    ev_gated;

   // ****************************************************************
   // shadow register index map
   // ****************************************************************
   function automatic logic [3:0] shadow_map(input logic [4:0] a);
      if (a >= REG_R8 && a <= REG_R14) begin
         shadow_map = {1'b1, 3'(a - REG_R8)};
      end else if (a == REG_R25) begin
         shadow_map = {1'b1, 3'(NSHADOW - 1)};
      end else begin
         shadow_map = 4'h0;
      end
   endfunction

   // interrupts masked while in handler mode
   always_comb begin
      ev_gated      = EVT;
      ev_gated.intr = EVT.intr & ~r.mode;
   end

   hed_prio u_prio (
      .ev               (ev_gated),
      .float_enable_bit (r.float_en),
      .hit              (trap_hit),
      .ofs              (trap_ofs)
   );

   hed_scratch #(.DEPTH(NSCRATCH)) u_scratch (
      .clk   (CLK_SYS),
      .we    (IPR_WE & r.mode),
      .waddr (IPR_ADDR),
      .wdata (IPR_WDATA),
      .raddr (IPR_ADDR),
      .rdata (scratch_rdata)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_r          = r;
      next_r.redirect = 1'b0;
      next_r.rps_push = 1'b0;
      next_r.e1       = 1'b0;
      call_kernel  = (r.cur_mode == MODE_KERNEL);
      call_illegal = ((CALL_FUNC >= FN_ILL_LO) && (CALL_FUNC <= FN_ILL_HI))
                   || (CALL_FUNC > FN_UNPRIV_MAX)
                   || ((CALL_FUNC <= FN_PRIV_MAX) && !call_kernel);
      {next_r.use_shadow, next_r.shadow_idx} =
         shadow_map(GPR_ADDR) & {4{r.mode & r.shadow_en}};
      if (BASE_WE && r.mode) begin
         next_r.base = IPR_WDATA;
      end
      if (CTL_WE && r.mode) begin
         next_r.cur_mode  = CTL_MODE;
         next_r.shadow_en = CTL_SHADOW;
         next_r.float_en  = CTL_FLOAT;
      end
      case (r.st)
         ST_RUN: begin
            if (EVT.replay) begin
               next_r.st = ST_RUN;
            end else if (trap_hit) begin
               next_r.st      = ST_DRAIN;
               next_r.drain   = 1'b1;
               next_r.stall   = 1'b1;
               next_r.is_call = 1'b0;
               next_r.ret     = {CUR_PC[XLEN-1:1], r.mode};
               next_r.rps_pc  = EVT.precise ? CUR_PC : LATER_PC;
               next_r.target  = {r.base[XLEN-1:14], trap_ofs[13:1], 1'b1};
            end else if (CALL_VALID) begin
               next_r.st      = ST_DRAIN;
               next_r.drain   = 1'b1;
               next_r.stall   = 1'b1;
               next_r.rps_pc  = CALL_NEXT_PC;
               if (call_illegal) begin
                  next_r.is_call = 1'b0;
                  next_r.ret     = {CUR_PC[XLEN-1:1], r.mode};
                  next_r.target  = {r.base[XLEN-1:14], OFS_ILLOP[13:1], 1'b1};
               end else begin
                  next_r.is_call = 1'b1;
                  next_r.ret     = CALL_NEXT_PC;
                  next_r.target  = {r.base[XLEN-1:14], 1'b1, CALL_FUNC[7],
                                    CALL_FUNC[5:0], 5'h00, 1'b1};
               end
            end else if (RET_VALID && r.mode) begin
               next_r.redirect = 1'b1;
               next_r.pc       = r.ret;
               next_r.mode     = r.ret[0];
            end
         end
         ST_DRAIN: begin
            if (PIPE_EMPTY) begin
               next_r.st    = ST_ISSUE;
               next_r.drain = 1'b0;
               next_r.e1    = r.is_call;
            end
         end
         ST_ISSUE: begin
            next_r.st       = ST_FLOW;
            next_r.redirect = 1'b1;
            next_r.pc       = r.target;
            next_r.mode     = 1'b1;
            next_r.rps_push = 1'b1;
            next_r.flow     = FLOW_CNT;
         end
         default: begin
            next_r.flow = r.flow - 2'h1;
            if (r.flow == 2'h1) begin
               next_r.st    = ST_RUN;
               next_r.stall = 1'b0;
            end
         end
      endcase
      if (EVT.reset_req) begin
         next_r.st    = ST_ISSUE;
         next_r.drain = 1'b0;
         next_r.stall = 1'b1;
         next_r.is_call = 1'b0;
         next_r.target  = {r.base[XLEN-1:14], OFS_RESET[13:1], 1'b1};
      end
      // enables registered from the next mode so the outputs come from flops
      next_r.intr_en = ~next_r.mode;
      next_r.imap_en = ~next_r.mode;
      next_r.dmap_en = 1'b1;
   end

   // ****************************************************************
   // registered state
   // ****************************************************************
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         r            <= '0;
         r.st         <= ST_ISSUE;
         r.stall      <= 1'b1;
         r.mode       <= 1'b1;
         r.dmap_en    <= 1'b1;
         r.base       <= BASE_RESET;
         r.target     <= RET_RESET;
         r.ret        <= RET_RESET;
         r.pc         <= RET_RESET;
      end else begin
         r <= next_r;
      end
   end

   // outputs
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         IPR_RDATA <= '0;
      end else begin
         IPR_RDATA <= (IPR_RE && r.mode) ? scratch_rdata : '0;
      end
   end

   assign REDIRECT     = r.redirect;
   assign NEW_PC       = r.pc;
   assign FETCH_PC     = {r.pc[XLEN-1:2], 2'b00};
   assign HANDLER_MODE = r.mode;
   assign INTR_ENABLE  = r.intr_en;
   assign IMAP_ENABLE  = r.imap_en;
   assign DMAP_ENABLE  = r.dmap_en;
   assign DRAIN_REQ    = r.drain;
   assign ISSUE_STALL  = r.stall;
   assign ISSUE_E1     = r.e1;
   assign RPS_PUSH     = r.rps_push;
   assign RPS_PC       = r.rps_pc;
   assign EXC_RET      = r.ret;
   assign USE_SHADOW   = r.use_shadow;
   assign SHADOW_IDX   = r.shadow_idx;
endmodule

// ===== test/hed_props.sv
`timescale 1ns/1ps
// ************************************************
// handler entry checker
// ************************************************
module hed_props
   import hed_pkg::*;
(
   input wire logic            CLK_SYS,
   input wire logic            RST,
   input wire hed_evt_t        EVT,
   input wire logic            CALL_VALID,
   input wire logic            RET_VALID,
   input wire logic [4:0]      GPR_ADDR,
   input wire logic            REDIRECT,
   input wire logic [XLEN-1:0] NEW_PC,
   input wire logic [XLEN-1:0] FETCH_PC,
   input wire logic            HANDLER_MODE,
   input wire logic            INTR_ENABLE,
   input wire logic            IMAP_ENABLE,
   input wire logic            DMAP_ENABLE,
   input wire logic            DRAIN_REQ,
   input wire logic            ISSUE_STALL,
   input wire logic            ISSUE_E1,
   input wire logic            RPS_PUSH,
   input wire logic [XLEN-1:0] EXC_RET,
   input wire logic            USE_SHADOW,
   input wire logic [2:0]      SHADOW_IDX
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   // mode flag, fetch address and enables follow the target
   redir_mode_a: assert property (REDIRECT |-> HANDLER_MODE == NEW_PC[0])
      else $error("mode flag differs from target bit 0");
   fetch_align_a: assert property (FETCH_PC == {NEW_PC[63:2], 2'b00})
      else $error("fetch address not aligned");
   mode_masks_a: assert property (INTR_ENABLE == !HANDLER_MODE && IMAP_ENABLE == !HANDLER_MODE
      && DMAP_ENABLE) else $error("enables do not follow mode");

   // call sequence: drain, issue, redirect, two flow cycles
   call_min_a: assert property (CALL_VALID && !ISSUE_STALL && EVT == '0
      |=> DRAIN_REQ && !REDIRECT ##1 !REDIRECT ##[1:40] REDIRECT) else $error("call too short");
   call_issue_a: assert property (ISSUE_E1 |=> REDIRECT && RPS_PUSH && NEW_PC[0])
      else $error("issue not followed by redirect");
   drain_bound_a: assert property ($rose(DRAIN_REQ) |-> ##[1:40] REDIRECT)
      else $error("drain never dispatched");
   flow_stall_a: assert property (REDIRECT && HANDLER_MODE && ISSUE_STALL
      |=> ISSUE_STALL ##1 !ISSUE_STALL) else $error("flow length wrong");
   shadow_map_a: assert property (USE_SHADOW |->
      ($past(GPR_ADDR) inside {[5'h08:5'h0e]} && SHADOW_IDX == 3'($past(GPR_ADDR) - 5'h08))
      || ($past(GPR_ADDR) == 5'h19 && SHADOW_IDX == 3'h7)) else $error("bad shadow map");
   ret_target_a: assert property (RET_VALID && HANDLER_MODE && !ISSUE_STALL && !CALL_VALID
      && EVT == '0 |=> REDIRECT && NEW_PC == $past(EXC_RET)) else $error("bad return");

   c_issue: cover property (ISSUE_E1);
   c_native: cover property (REDIRECT && !HANDLER_MODE);
   c_shadow: cover property (USE_SHADOW && SHADOW_IDX == 3'h7);
endmodule

bind hed_dispatch hed_props u_props (.*);

// ===== test/hed_pipe_model.sv
`timescale 1ns/1ps
// ************************************************
// pipeline drain model
// ************************************************
module hed_pipe_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       drain_req,
   input  wire logic [3:0] slow,
   output logic            pipe_empty
);
   logic [3:0] cnt;

   // count drain cycles, empty once the set latency has passed
   always_ff @(posedge clk) begin
      if (rst || !drain_req) begin
         cnt <= 4'h0;
      end else if (cnt != 4'hf) begin
         cnt <= cnt + 4'h1;
      end
   end
   assign pipe_empty = !rst && (cnt >= slow);
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
// ************************************************
// handler entry testbench
// ************************************************
module testbench;
   import hed_pkg::*;
   logic            CLK_SYS = 1'b0;
   logic            RST = 1'b1;
   hed_evt_t        EVT = '0;
   logic [XLEN-1:0] CUR_PC = 64'h0000_0000_4000_1230;
   logic [XLEN-1:0] LATER_PC = 64'h0000_0000_4000_1238;
   logic [XLEN-1:0] CALL_NEXT_PC = 64'h0000_0000_5000_0104;
   logic [XLEN-1:0] IPR_WDATA = '0;
   logic [XLEN-1:0] NEW_PC, FETCH_PC, RPS_PC, EXC_RET, IPR_RDATA;
   logic            CALL_VALID = 1'b0, RET_VALID = 1'b0, IPR_WE = 1'b0, IPR_RE = 1'b0;
   logic            BASE_WE = 1'b0, CTL_WE = 1'b0, CTL_SHADOW = 1'b1, CTL_FLOAT = 1'b0;
   logic [1:0]      CTL_MODE = 2'h0;
   logic [4:0]      IPR_ADDR = 5'h00, GPR_ADDR = 5'h00;
   logic [7:0]      CALL_FUNC = 8'h00;
   logic            PIPE_EMPTY, REDIRECT, HANDLER_MODE, INTR_ENABLE, IMAP_ENABLE, DMAP_ENABLE;
   logic            DRAIN_REQ, ISSUE_STALL, ISSUE_E1, RPS_PUSH, USE_SHADOW;
   logic [2:0]      SHADOW_IDX;
   logic [3:0]      slow = 4'h0;
   logic [63:0]     bas = 64'h0000_0012_3456_4000;
   logic [63:0]     sv5 = 64'h0123_4567_89ab_cdef;
   logic [16:0]     tev [14] = '{17'h0c001, 17'h06000, 17'h07000, 17'h02801, 17'h00c00,
      17'h00a00, 17'h00500, 17'h00180, 17'h000c1, 17'h00060, 17'h00031, 17'h00018,
      17'h00008, 17'h0000d};
   logic [13:0]     tofs [14] = '{OFS_IACC, OFS_INTR, OFS_ITBM, OFS_ITBM, OFS_DMISS,
      OFS_DFLT, OFS_DMISS2, OFS_UNAL, OFS_DFLT, OFS_HWERR, OFS_ILLOP, OFS_ARITHMETIC_ENTRY,
      OFS_FPDIS, OFS_FPDIS};
   logic [7:0]      ill [4] = '{8'h40, 8'h7f, 8'hc0, 8'hff};
   logic [4:0]      gprs [4] = '{5'h08, 5'h0e, 5'h19, 5'h0f};
   logic [3:0]      shx [4] = '{4'h8, 4'he, 4'hf, 4'h0};
   int              num_errors = 0, tests_run = 0;

   hed_dispatch u_dut (.*);
   hed_pipe_model u_pipe (.clk(CLK_SYS), .rst(RST), .drain_req(DRAIN_REQ), .slow(slow),
      .pipe_empty(PIPE_EMPTY));

   // clock
   always #50 CLK_SYS = ~CLK_SYS;

   // ************************************************
   // helpers
   // ************************************************
   function automatic logic [63:0] tgt(input logic [13:0] o);
      return {bas[63:14], 14'h0} + 64'(o) + 64'h1;
   endfunction
   task automatic step();
      @(posedge CLK_SYS);
      #1;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_redir();
      int k;
      k = 0;
      while (REDIRECT !== 1'b1 && k < 40) begin
         step();
         k++;
      end
      chk(64'(k < 40), 64'h1);
   endtask
   task automatic fire(input logic [16:0] e, input logic c, input logic r, input logic [7:0] f);
      while (ISSUE_STALL !== 1'b0) step();
      @(posedge CLK_SYS);
      EVT <= hed_evt_t'(e);
      CALL_VALID <= c;
      RET_VALID <= r;
      CALL_FUNC <= f;
      @(posedge CLK_SYS);
      EVT <= '0;
      CALL_VALID <= 1'b0;
      RET_VALID <= 1'b0;
      #1;
      wait_redir();
   endtask
   task automatic ret_native(input logic [63:0] pc);
      fire(17'h0, 1'b0, 1'b1, 8'h00);
      chk(NEW_PC, pc);
      chk(64'({HANDLER_MODE, INTR_ENABLE, IMAP_ENABLE}), 64'h3);
   endtask
   task automatic quiet(input logic [16:0] e);
      @(posedge CLK_SYS);
      EVT <= hed_evt_t'(e);
      repeat (4) begin
         step();
         chk(64'(REDIRECT | DRAIN_REQ), 64'h0);
      end
      @(posedge CLK_SYS);
      EVT <= '0;
   endtask
   task automatic wr(input logic [2:0] sel, input logic [4:0] a, input logic [63:0] d);
      @(posedge CLK_SYS);
      {CTL_WE, BASE_WE, IPR_WE} <= sel;
      IPR_ADDR <= a;
      IPR_WDATA <= d;
      @(posedge CLK_SYS);
      {CTL_WE, BASE_WE, IPR_WE} <= 3'h0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [63:0] exp);
      @(posedge CLK_SYS);
      IPR_RE <= 1'b1;
      IPR_ADDR <= a;
      @(posedge CLK_SYS);
      IPR_RE <= 1'b0;
      #1;
      chk(IPR_RDATA, exp);
   endtask
   task automatic close_out();
      $display("mismatches %0d compares %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ************************************************
   // tests
   // ************************************************
   initial begin
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      #1;
      wait_redir();
      chk(NEW_PC, 64'h1);
      chk(64'(HANDLER_MODE), 64'h1);
      repeat (3) step();
      wr(3'h2, 5'h00, bas);
      wr(3'h4, 5'h00, 64'h0);
      wr(3'h1, 5'h05, sv5);
      wr(3'h1, 5'h17, ~sv5);
      rd(5'h05, sv5);
      rd(5'h17, ~sv5);
      foreach (gprs[i]) begin
         @(posedge CLK_SYS);
         GPR_ADDR <= gprs[i];
         step();
         chk(64'({USE_SHADOW, SHADOW_IDX}), 64'(shx[i]));
      end
      slow <= 4'h3;
      fire(17'h0, 1'b1, 1'b0, 8'h01);
      chk(NEW_PC, {bas[63:14], 2'b10, 6'h01, 6'h01});
      chk(EXC_RET, CALL_NEXT_PC);
      chk(RPS_PC, CALL_NEXT_PC);
      ret_native(CALL_NEXT_PC);
      wr(3'h1, 5'h05, 64'h0);
      slow <= 4'h0;
      fire(17'h0, 1'b1, 1'b0, 8'h83);
      chk(NEW_PC, {bas[63:14], 2'b11, 6'h03, 6'h01});
      ret_native(CALL_NEXT_PC);
      foreach (ill[i]) begin
         fire(17'h0, 1'b1, 1'b0, ill[i]);
         chk(NEW_PC, tgt(OFS_ILLOP));
         ret_native(CUR_PC);
      end
      foreach (tev[i]) begin
         fire(tev[i], 1'b0, 1'b0, 8'h00);
         chk(NEW_PC, tgt(tofs[i]));
         chk(EXC_RET, CUR_PC);
         chk(RPS_PC, tev[i][0] ? CUR_PC : LATER_PC);
         ret_native(CUR_PC);
      end
      quiet(17'h00002);
      fire(17'h08000, 1'b0, 1'b0, 8'h00);
      rd(5'h05, sv5);
      quiet(17'h04000);
      CTL_MODE <= 2'h3;
      wr(3'h4, 5'h00, 64'h0);
      ret_native(CUR_PC);
      fire(17'h0, 1'b1, 1'b0, 8'h01);
      chk(NEW_PC, tgt(OFS_ILLOP));
      ret_native(CUR_PC);
      close_out();
   end

   // watchdog
   initial begin
      #1_000_000;
      num_errors++;
      close_out();
   end
endmodule
